// File: dv/bus_master_model.sv
// Bus master model: one command at a time, answers gathered
`timescale 1ns/100ps
module bus_master_model (
   // Clock
   input wire logic CLK,
   // Command
   output logic CMD_VALID,
   output logic CMD_CRC_ERR,
   output logic [3:0] CMD_ADDR,
   output logic [3:0] CMD_CODE,
   output logic [7:0] CMD_DATA,
   // Response
   input wire logic RESP_VALID,
   input wire logic [15:0] RESP_DATA
);
   int n_resp;
   logic [15:0] last_resp;
   initial {CMD_VALID, CMD_CRC_ERR, CMD_ADDR, CMD_CODE, CMD_DATA} = '0;
   task automatic send(input logic [3:0] a, c, input logic [7:0] d, input logic crc);
      @(negedge CLK);
      {CMD_VALID, CMD_CRC_ERR, CMD_ADDR, CMD_CODE, CMD_DATA} = {1'b1, crc, a, c, d};
      @(negedge CLK);
      // Fields are not held after the strobe, so scramble them
      {CMD_VALID, CMD_ADDR, CMD_CODE, CMD_DATA} = {1'b0, ~a, ~c, ~d};
      n_resp = 0;
      repeat (3) begin
         @(negedge CLK);
         if (RESP_VALID === 1'b1) begin
            n_resp++;
            last_resp = RESP_DATA;
         end
      end
   endtask
endmodule

// File: dv/resp_fmt_props.sv
// Port assertions for the response formatter
`timescale 1ns/100ps
module resp_fmt_checker
   import resp_fmt_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Command
   input wire logic CMD_VALID,
   input wire logic CMD_CRC_ERR,
   input wire logic [3:0] CMD_ADDR,
   input wire logic [3:0] CMD_CODE,
   // Sensor state
   input wire logic CUSTOMER_LOCK_BIT,
   input wire logic [1:0] DEVICE_CONFIG_ONE,
   input wire logic GND_LOSS_DETECT_EN,
   input wire logic GND_FAULT_DETECTED,
   input wire logic [9:0] ACCEL_RESULT,
   // Outputs
   input wire logic SELFTEST_ACTIVE,
   input wire logic [3:0] BUS_NODE_ADDRESS,
   input wire logic RESP_VALID,
   input wire logic [15:0] RESP_DATA
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // Global address answers only to init, so it is left out of a take
   wire logic take = CMD_VALID && !CMD_CRC_ERR && CMD_ADDR == BUS_NODE_ADDRESS
      && CMD_ADDR != GLOBAL_ADDR;
   AST_CRC_DROP: assert property (CMD_VALID && CMD_CRC_ERR |-> ##1 !RESP_VALID [*3])
      else $error("answer to a corrupted command");
   AST_ONE_PULSE: assert property (RESP_VALID |=> !RESP_VALID)
      else $error("answer repeated");
   AST_ADDR_FIELD: assert property (RESP_VALID |-> RESP_DATA[15:12] == BUS_NODE_ADDRESS)
      else $error("address field wrong");
   AST_ACCEL: assert property (take && CMD_CODE == CMD_READ_ACCEL |->
      ##2 RESP_VALID && RESP_DATA[9:0] == $past(ACCEL_RESULT)) else $error("accel field wrong");
   AST_ID: assert property (take && CMD_CODE == CMD_REQ_ID |->
      ##2 RESP_VALID && RESP_DATA[11:0] == {4'h0, VERSION_CODE, ID_PATTERN})
      else $error("id answer wrong");
   AST_GND: assert property (take && CMD_CODE == CMD_STATUS |->
      ##2 RESP_DATA[0] == (GND_LOSS_DETECT_EN && GND_FAULT_DETECTED)) else $error("gf wrong");
   AST_ATTR: assert property (take && CMD_CODE == CMD_STATUS |->
      ##2 RESP_DATA[3:2] == (CUSTOMER_LOCK_BIT ? DEVICE_CONFIG_ONE : ATTR_UNLOCKED))
      else $error("attribute wrong");
   AST_ST_ON: assert property (take && CMD_CODE == CMD_ST_ON |->
      ##2 RESP_DATA[5] && SELFTEST_ACTIVE) else $error("self-test flag wrong");
endmodule
bind sensor_bus_response_formatter resp_fmt_checker chk (.CLK(CLK), .RST_B(RST_B),
   .CMD_VALID(CMD_VALID), .CMD_CRC_ERR(CMD_CRC_ERR), .CMD_ADDR(CMD_ADDR), .CMD_CODE(CMD_CODE),
   .CUSTOMER_LOCK_BIT(CUSTOMER_LOCK_BIT), .DEVICE_CONFIG_ONE(DEVICE_CONFIG_ONE),
   .GND_LOSS_DETECT_EN(GND_LOSS_DETECT_EN), .GND_FAULT_DETECTED(GND_FAULT_DETECTED),
   .ACCEL_RESULT(ACCEL_RESULT), .SELFTEST_ACTIVE(SELFTEST_ACTIVE),
   .BUS_NODE_ADDRESS(BUS_NODE_ADDRESS), .RESP_VALID(RESP_VALID), .RESP_DATA(RESP_DATA));

// File: dv/tb_top.sv
// Self-checking bench for the response formatter
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import resp_fmt_pkg::*;
   logic clk, rst_b, lock, gen, gfd, ie, uv, btf, st_m, cv, ce, prog, sw, st, rv;
   logic pe_m, sw_m;
   logic [1:0] cfg;
   logic [9:0] acc;
   logic [7:0] urv, d, cd;
   logic [3:0] nrd, c, uri, addr, wd, ca, cc;
   logic [5:0] sel;
   logic [15:0] rd;
   logic [3:0] fmt [8];
   logic [3:0] codes [8] = '{CMD_STATUS, CMD_READ_ACCEL, CMD_REQ_ID, CMD_NVM, CMD_FORMAT,
      CMD_READ_REG, CMD_ST_OFF, CMD_ST_ON};
   logic [3:0] bad [6] = '{4'h3, 4'h5, 4'h6, 4'h8, 4'he, CMD_CLEAR};
   int cycles, failures, num_checks;
   bus_master_model m (.CLK(clk), .CMD_VALID(cv), .CMD_CRC_ERR(ce), .CMD_ADDR(ca),
      .CMD_CODE(cc), .CMD_DATA(cd), .RESP_VALID(rv), .RESP_DATA(rd));
   sensor_bus_response_formatter DUT (.CLK(clk), .RST_B(rst_b), .CMD_VALID(cv),
      .CMD_CRC_ERR(ce), .CMD_ADDR(ca), .CMD_CODE(cc), .CMD_DATA(cd), .PRESET_ADDR(4'h0),
      .CUSTOMER_LOCK_BIT(lock), .DEVICE_CONFIG_ONE(cfg), .GND_LOSS_DETECT_EN(gen),
      .GND_FAULT_DETECTED(gfd), .INTERNAL_ERROR(ie), .UNDERVOLTAGE(uv), .ACCEL_RESULT(acc),
      .BUS_TEST_FAIL(btf), .USER_REG_INDEX(uri), .USER_REG_VALUE(urv), .NVM_PROG(prog),
      .NVM_SEL(sel), .NVM_WDATA(wd), .NVM_RDATA(nrd), .SWITCH_CLOSED(sw),
      .SELFTEST_ACTIVE(st), .BUS_NODE_ADDRESS(addr), .RESP_VALID(rv), .RESP_DATA(rd));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         complete_run();
      end
   end
   function automatic logic [15:0] exp_resp(input logic [3:0] k, input logic [7:0] x);
      case (k)
         CMD_READ_ACCEL: return {4'h5, gen & gfd, ie, acc};
         CMD_REQ_ID: return {4'h5, 4'h0, VERSION_CODE, ID_PATTERN};
         CMD_NVM: return {4'h5, x[7:4], x[7:4], pe_m ? x[3:0] : nrd};
         CMD_FORMAT: return {4'h5, FMT_PATTERN, x[7:4], x[7] ? x[3:0] : fmt[x[6:4]]};
         CMD_READ_REG: return {4'h5, x[3:0], urv};
         default: return {8'h50, pe_m, uv, st_m, sw_m, lock ? cfg : ATTR_UNLOCKED, ie, gen & gfd};
      endcase
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic run(input logic [3:0] a, k, input logic [7:0] x, input logic e, int n);
      logic [15:0] ex;
      ex = exp_resp(k, x);
      m.send(a, k, x, e);
      `CHK("answers", n, m.n_resp)
      if (n == 1 && k != CMD_INIT && k != CMD_REV_INIT) `CHK("answer", ex, m.last_resp)
   endtask
   initial begin
      {clk, rst_b, lock, gen, gfd, ie, uv, btf, st_m, pe_m, sw_m, cfg, acc, urv, nrd} = '0;
      foreach (fmt[i]) fmt[i] = FMT_REG_RST;
      void'($urandom(68));
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      btf = 1'b1;
      run(4'h0, CMD_REV_INIT, 8'h53, 1'b0, 1);
      `CHK("fault answer", {4'h3, 4'h1, 8'h13}, m.last_resp)
      // Second reset mid-run must drop the assigned address
      rst_b = 1'b0;
      repeat (3) @(negedge clk);
      {rst_b, btf} = 2'b10;
      `CHK("address", ADDR_RST, addr)
      run(4'h0, CMD_INIT, 8'h75, 1'b0, 0);
      run(4'h0, CMD_INIT, 8'h50, 1'b0, 0);
      run(4'h0, CMD_INIT, 8'h55, 1'b1, 0);
      run(4'h0, CMD_INIT, 8'h55, 1'b0, 1);
      `CHK("init answer", {4'h5, 4'h0, 8'h55}, m.last_resp)
      `CHK("address", 4'h5, addr)
      `CHK("switch", 1'b1, sw)
      sw_m = 1'b1;
      for (int i = 0; i < 80; i++) begin
         {lock, gen, gfd, uv, cfg, acc, urv, nrd, d} = 36'({$urandom, $urandom});
         c = codes[$urandom_range(0, 7)];
         if (c == CMD_READ_REG) d[7:4] = 4'h0;
         if (c == CMD_ST_ON || c == CMD_ST_OFF) st_m = (c == CMD_ST_ON);
         // Any flagged condition may also raise the summary bit
         ie = 1'($urandom) | uv | st_m | (gen & gfd);
         run(4'h5, c, d, 1'b0, 1);
         if (c == CMD_FORMAT && d[7]) fmt[d[6:4]] = d[3:0];
         if (c == CMD_NVM) `CHK("nvm select", {d[7:4], 2'b01}, sel)
         if (c == CMD_NVM) `CHK("nvm program", 1'b0, prog)
         if (c == CMD_READ_REG) `CHK("user index", d[3:0], uri)
      end
      st_m = 1'b1;
      ie = 1'b1;
      run(4'h5, CMD_ST_ON, 8'h00, 1'b0, 1);
      foreach (bad[i]) run(4'h5, bad[i], 8'h00, 1'b0, 0);
      st_m = 1'b0;
      run(4'h5, CMD_STATUS, 8'h00, 1'b0, 1);
      run(4'h9, CMD_STATUS, 8'h00, 1'b0, 0);
      run(4'h0, CMD_FORMAT, 8'h30, 1'b0, 0);
      run(4'h5, CMD_FORMAT, 8'hf9, 1'b0, 1);
      fmt[7] = 4'h9;
      run(4'h5, CMD_FORMAT, 8'h70, 1'b0, 1);
      // Re-initialise a preset address with programming on and the switch open
      pe_m = 1'b1;
      sw_m = 1'b0;
      run(4'h5, CMD_INIT, 8'h95, 1'b0, 1);
      `CHK("reinit answer", {4'h5, 4'h0, 8'h95}, m.last_resp)
      run(4'h5, CMD_NVM, 8'h3a, 1'b0, 1);
      `CHK("nvm data", 4'ha, wd)
      `CHK("nvm select", {4'h3, 2'b01}, sel)
      run(4'h5, CMD_STATUS, 8'h00, 1'b0, 1);
      complete_run();
   end
endmodule

// File: src/fmt_reg_file.sv
// Eight 4-bit format control registers
`timescale 1ns/100ps
module fmt_reg_file
   import resp_fmt_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   fmt_reg_if.regs fr
);
   logic [3:0] regs_ff [FMT_REGS];
   assign fr.rd_data = regs_ff[fr.index];

   always_ff @(posedge CLK) begin
      for (int i = 0; i < FMT_REGS; i++) begin
         if (!RST_B) begin
            regs_ff[i] <= FMT_REG_RST;
         end else if (fr.wr_en && fr.index == 3'(i)) begin
            regs_ff[i] <= fr.wr_data;
         end
      end
   end
endmodule

// File: src/fmt_reg_if.sv
// Interface: access path from the decoder to the format register file
`timescale 1ns/100ps
interface fmt_reg_if;
   logic wr_en;
   logic [2:0] index;
   logic [3:0] wr_data;
   logic [3:0] rd_data;
   modport ctrl (output wr_en, output index, output wr_data, input rd_data);
   modport regs (input wr_en, input index, input wr_data, output rd_data);
endinterface

// File: src/resp_fmt_pkg.sv
// Package: command codes, response field layout and reset values for the response formatter
package resp_fmt_pkg;
   localparam logic [3:0] CMD_INIT = 4'h0;
   localparam logic [3:0] CMD_STATUS = 4'h1;
   localparam logic [3:0] CMD_READ_ACCEL = 4'h2;
   localparam logic [3:0] CMD_REQ_ID = 4'h4;
   localparam logic [3:0] CMD_CLEAR = 4'h7;
   localparam logic [3:0] CMD_NVM = 4'h9;
   localparam logic [3:0] CMD_FORMAT = 4'ha;
   localparam logic [3:0] CMD_READ_REG = 4'hb;
   localparam logic [3:0] CMD_ST_OFF = 4'hc;
   localparam logic [3:0] CMD_ST_ON = 4'hd;
   localparam logic [3:0] CMD_REV_INIT = 4'hf;
   localparam logic [3:0] GLOBAL_ADDR = 4'h0;
   localparam logic [4:0] ID_PATTERN = 5'h04;
   localparam logic [3:0] FMT_PATTERN = 4'h6;
   localparam logic [1:0] ATTR_UNLOCKED = 2'h2;
   // Arbitrary neutral version code
   localparam logic [2:0] VERSION_CODE = 3'h1;
   localparam logic [1:0] BANK_INVALID = 2'h3;
   localparam logic [3:0] ADDR_RST = 4'h0;
   localparam logic [3:0] FMT_REG_RST = 4'h0;
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 12;
   localparam int FMT_REGS = 8;
endpackage

// File: src/sensor_bus_response_formatter.sv
// Command decoder and long-word response formatter for the sensor bus slave
`timescale 1ns/100ps
// Contract
// - Address in 15:12; ID response layout
// - Accel response: ground fault, status, result
// - Status and self-test response bit order
// - Self-test and error flags reported as set
// - Format response: 0110, rw, index, data
// - Read-register response: index and contents
// - Init response: fault, nv, switch, bank, address
// - Address from preset; zero allows assignment
// - Attribute forced to 10 until locked
// - Bank stored; invalid bank gets no response
// - Bus test result reported as fault flag
// - Switch bit closes switch unless bus test failed; state reported
// - Three-bit index selects one of eight
// - Format write stores, read returns contents
// - Ground fault only when detection enabled
// - Programming enable taken at initialization
// - Assigned address taken and reported
// - NVM location from index plus bank
// - NVM program when enabled, else read
// - Format rw flag; global read ignored
// - No response on CRC error or bad code
// - At most one response per command, no retry
module sensor_bus_response_formatter
   import resp_fmt_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Decoded command from the link layer
   input wire logic CMD_VALID,
   input wire logic CMD_CRC_ERR,
   input wire logic [3:0] CMD_ADDR,
   input wire logic [3:0] CMD_CODE,
   input wire logic [7:0] CMD_DATA,
   // Configuration and sensor state
   input wire logic [3:0] PRESET_ADDR,
   input wire logic CUSTOMER_LOCK_BIT,
   input wire logic [1:0] DEVICE_CONFIG_ONE,
   input wire logic GND_LOSS_DETECT_EN,
   input wire logic GND_FAULT_DETECTED,
   input wire logic INTERNAL_ERROR,
   input wire logic UNDERVOLTAGE,
   input wire logic [9:0] ACCEL_RESULT,
   input wire logic BUS_TEST_FAIL,
   // User register read port
   output logic [3:0] USER_REG_INDEX,
   input wire logic [7:0] USER_REG_VALUE,
   // Nonvolatile memory port
   output logic NVM_PROG,
   output logic [5:0] NVM_SEL,
   output logic [3:0] NVM_WDATA,
   input wire logic [3:0] NVM_RDATA,
   // Device state
   output logic SWITCH_CLOSED,
   output logic SELFTEST_ACTIVE,
   output logic [3:0] BUS_NODE_ADDRESS,
   // Response
   output logic RESP_VALID,
   output logic [15:0] RESP_DATA
);
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SEND} state_t;

   state_t state_ff, nxt_state;
   logic [3:0] addr_ff, code_ff;
   logic [7:0] data_ff;
   logic [3:0] node_addr_ff;
   logic addr_loaded_ff;
   logic [1:0] bank_ff;
   logic prog_en_ff, switch_ff, selftest_ff;
   logic resp_valid_ff;
   logic [15:0] resp_ff, nxt_resp;
   logic [3:0] user_idx_ff;
   logic nvm_prog_ff;
   logic [5:0] nvm_sel_ff;
   logic [3:0] nvm_wdata_ff;
   logic send_ok;

   fmt_reg_if fr ();
   fmt_reg_file u_fmt (.CLK(CLK), .RST_B(RST_B), .fr(fr));

   // Command field decode
   wire is_init = (code_ff == CMD_INIT) || (code_ff == CMD_REV_INIT);
   wire is_global = (addr_ff == GLOBAL_ADDR);
   wire for_me = !is_global && (addr_ff == node_addr_ff);
   wire [3:0] pa = data_ff[3:0];
   wire [1:0] bank_req = data_ff[5:4];
   // Preset device: both fields match preset; blank device: address field zero
   wire init_addr_ok = (pa != 4'h0) && ((node_addr_ff == 4'h0) ? (addr_ff == 4'h0)
                       : (addr_ff == node_addr_ff && pa == node_addr_ff));
   wire init_ok = init_addr_ok && (bank_req != BANK_INVALID);
   wire fmt_wr = (code_ff == CMD_FORMAT) && data_ff[7];
   wire [1:0] attr = CUSTOMER_LOCK_BIT ? DEVICE_CONFIG_ONE : ATTR_UNLOCKED;
   wire gf = GND_LOSS_DETECT_EN & GND_FAULT_DETECTED;
   // Self-test commands report the state they leave behind, in both ST and summary bits
   wire st_now = (code_ff == CMD_ST_ON) ? 1'b1
                 : (code_ff == CMD_ST_OFF) ? 1'b0 : selftest_ff;
   wire stat = INTERNAL_ERROR | st_now | UNDERVOLTAGE | gf;
   wire [7:0] status_byte = {prog_en_ff, UNDERVOLTAGE, st_now, switch_ff,
                             attr, stat, gf};
   wire nxt_switch = init_ok ? (data_ff[6] & !BUS_TEST_FAIL) : switch_ff;

   assign fr.index = data_ff[6:4];
   assign fr.wr_data = data_ff[3:0];
   assign fr.wr_en = (state_ff == ST_EXEC) && fmt_wr && (for_me || is_global);

   // Response selection and whether one is owed
   always_comb begin
      nxt_resp = {addr_ff, 12'h000};
      send_ok = for_me;
      case (code_ff)
         CMD_INIT, CMD_REV_INIT: begin
            send_ok = init_ok;
            nxt_resp = {pa, 3'h0, BUS_TEST_FAIL, prog_en_ff | data_ff[7],
                        nxt_switch, bank_req, pa};
         end
         CMD_STATUS, CMD_ST_OFF, CMD_ST_ON: begin
            nxt_resp = {node_addr_ff, 4'h0, status_byte};
         end
         CMD_READ_ACCEL: nxt_resp = {node_addr_ff, gf, stat, ACCEL_RESULT};
         CMD_REQ_ID: nxt_resp = {node_addr_ff, 4'h0, VERSION_CODE, ID_PATTERN};
         CMD_FORMAT: nxt_resp = {node_addr_ff, FMT_PATTERN, data_ff[7], data_ff[6:4],
                                 fmt_wr ? data_ff[3:0] : fr.rd_data};
         CMD_READ_REG: nxt_resp = {node_addr_ff, data_ff[3:0], USER_REG_VALUE};
         CMD_NVM: nxt_resp = {node_addr_ff, data_ff[7:4], data_ff[7:4],
                              prog_en_ff ? data_ff[3:0] : NVM_RDATA};
         default: send_ok = 1'b0;
      endcase
   end

   always_comb begin
      case (state_ff)
         ST_IDLE: nxt_state = (CMD_VALID && !CMD_CRC_ERR) ? ST_EXEC : ST_IDLE;
         ST_EXEC: nxt_state = send_ok ? ST_SEND : ST_IDLE;
         ST_SEND: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         state_ff <= ST_IDLE;
         addr_ff <= 4'h0;
         code_ff <= 4'h0;
         data_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == ST_IDLE && CMD_VALID) begin
            addr_ff <= CMD_ADDR;
            code_ff <= CMD_CODE;
            data_ff <= CMD_DATA;
         end
      end
   end

   // Preset address is caught in the first cycle after reset release
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         node_addr_ff <= ADDR_RST;
         addr_loaded_ff <= 1'b0;
      end else if (!addr_loaded_ff) begin
         node_addr_ff <= PRESET_ADDR;
         addr_loaded_ff <= 1'b1;
      end else if (state_ff == ST_EXEC && is_init && init_ok) begin
         node_addr_ff <= pa;
      end
   end

   // Bank and switch are rewritten by each accepted init, programming enable is only ever set by one and cleared only by reset
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         bank_ff <= 2'h0;
         prog_en_ff <= 1'b0;
         switch_ff <= 1'b0;
      end else if (state_ff == ST_EXEC && is_init && init_ok) begin
         bank_ff <= bank_req;
         prog_en_ff <= prog_en_ff | data_ff[7];
         switch_ff <= nxt_switch;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         selftest_ff <= 1'b0;
      end else if (state_ff == ST_EXEC && (for_me || is_global)) begin
         if (code_ff == CMD_ST_ON) begin
            selftest_ff <= 1'b1;
         end else if (code_ff == CMD_ST_OFF || code_ff == CMD_CLEAR) begin
            selftest_ff <= 1'b0;
         end
      end
   end

   // NVM and user register side effects; NVM_PROG pulses once per addressed NVM command while programming is enabled
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         nvm_prog_ff <= 1'b0;
         nvm_sel_ff <= 6'h00;
         nvm_wdata_ff <= 4'h0;
         user_idx_ff <= 4'h0;
      end else begin
         nvm_prog_ff <= (state_ff == ST_IDLE) && CMD_VALID && !CMD_CRC_ERR
                        && CMD_CODE == CMD_NVM && CMD_ADDR == node_addr_ff
                        && CMD_ADDR != GLOBAL_ADDR && prog_en_ff;
         if (state_ff == ST_IDLE && CMD_VALID) begin
            nvm_sel_ff <= {CMD_DATA[7:4], bank_ff};
            nvm_wdata_ff <= CMD_DATA[3:0];
            user_idx_ff <= CMD_DATA[3:0];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         resp_valid_ff <= 1'b0;
         resp_ff <= 16'h0000;
      end else begin
         resp_valid_ff <= (state_ff == ST_EXEC) && send_ok;
         if (state_ff == ST_EXEC && send_ok) begin
            resp_ff <= nxt_resp;
         end
      end
   end

   assign RESP_VALID = resp_valid_ff;
   assign RESP_DATA = resp_ff;
   assign BUS_NODE_ADDRESS = node_addr_ff;
   assign SWITCH_CLOSED = switch_ff;
   assign SELFTEST_ACTIVE = selftest_ff;
   assign NVM_PROG = nvm_prog_ff;
   assign NVM_SEL = nvm_sel_ff;
   assign NVM_WDATA = nvm_wdata_ff;
   assign USER_REG_INDEX = user_idx_ff;
endmodule
